// [hw/flash_ctrl_params.svh]
`ifndef FLASH_CTRL_PARAMS_SVH
`define FLASH_CTRL_PARAMS_SVH
// ============================================================
// special-register port addresses
`define FCR_ADDR      8'hD1
`define ACR_ADDR      8'hA2
`define FCR_RESET     8'h00
`define SFR_IDLE_READ 8'h00
// ============================================================
// flash control register field positions
`define FCR_BUSY_BIT  0
`define FCR_SPACE_LSB 1
`define FCR_SPACE_MSB 2
`define FCR_LMAP_BIT  3
`define FCR_KEY_LSB   4
`define FCR_KEY_MSB   7
// ============================================================
// aux control register field positions
`define ACR_BOOT_BIT  5
// ============================================================
// launch key values
`define KEY_ARM       4'h5
`define KEY_GO        4'hA
// ============================================================
// address map
`define USER_LAST     16'h3FFF
`define EXTRA_ROW_BASE     16'hFF80
`define BOOT_BASE     16'hF800
`define HSB_ADDR      16'h0000
`define HSB_SW_MSB    7
`define HSB_SW_LSB    4
`define HSB_HW_MSB    3
`define ERASED_BYTE   8'hFF
`endif

// [hw/flash_ctrl_pkg.sv]
package flash_ctrl_pkg;
  // ==========================================================
  // target space of mapping and programming
  typedef enum logic [1:0] {
    SPACE_USER,
    SPACE_EXTRA_ROW,
    SPACE_HSB,
    SPACE_RSVD
  } space_e;
  // ==========================================================
  // programming sequencer states
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_ERASE,
    OP_PROG
  } op_state_e;
endpackage

// [hw/page_latch.sv]
module page_latch
  import flash_ctrl_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int DEPTH  = 128,
  parameter int IDX_W  = $clog2(DEPTH)
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              wr,
  input  wire logic [IDX_W-1:0]  widx,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              clr,
  input  wire logic [IDX_W-1:0]  ridx,
  output logic      [DATA_W-1:0] rdata,
  output logic                   rvalid
);
  // ==========================================================
  // state: one loaded flag per byte position
  typedef struct packed {
    logic [DEPTH-1:0] loaded;
  } lat_s;
  lat_s              q, d;
  logic [DATA_W-1:0] mem [DEPTH];   // byte storage, no reset needed
  // flags: a load in the clearing cycle survives
  always_comb begin
    d = q;
    if (clr) begin
      d.loaded = '0;
    end
    if (wr) begin
      d.loaded[widx] = 1'b1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  // data bytes
  always_ff @(posedge clk) begin
    if (wr) begin
      mem[widx] <= wdata;
    end
  end
  assign rdata  = mem[ridx];
  assign rvalid = q.loaded[ridx];
endmodule // page_latch

// [hw/key_sequencer.sv]
module key_sequencer
  import flash_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       key_wr,     // control register write
  input  wire logic [3:0] key_nib,    // launch key nibble written
  input  wire logic       instr_end,  // an instruction retired
  input  wire logic       allow_go,   // launch permitted now
  output logic            go          // one-cycle launch pulse
);
  `include "flash_ctrl_params.svh"
  // ==========================================================
  // state: unlock armed, and one instruction seen since arming
  typedef struct packed {
    logic armed;
    logic gap;
  } seq_s;
  seq_s q, d;
  // arm on key 5, fire on key A in the very next instruction
  always_comb begin
    d = q;
    if (instr_end && q.armed) begin
      if (q.gap) begin
        d.armed = 1'b0;
      end
      d.gap = 1'b1;
    end
    if (key_wr) begin
      d.armed = (key_nib == `KEY_ARM);
      d.gap   = 1'b0;
    end
  end
  // launch only from an armed state, never from a fresh write
  assign go = key_wr && (key_nib == `KEY_GO) && q.armed && allow_go;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  // ==========================================================
  // checks
  a_gap_abort: assert property (@(posedge clk) disable iff (rst)
    q.armed && q.gap && instr_end && !key_wr |=> !q.armed && !go)
    else $error("unlock survived an intervening instruction");
  a_stray_key: assert property (@(posedge clk) disable iff (rst)
    q.armed && key_wr && key_nib != `KEY_ARM |=> !q.armed)
    else $error("stray key write did not drop the unlock");
endmodule // key_sequencer

// [hw/flash_program_memory_ctrl.sv]
// Behaviour
// - user array is 128 pages of 128 bytes
// - separate 128-byte extra row for boot data
// - security byte: software upper nibble only
// - one-page latch stages every software array write
// - only boot-array code may launch programming
// - boot array has no software write path
// - latch map lets data writes load latches
// - latch map wins over eeprom map enable
// - space select picks the code-read space
// - key 5 then key A launches programming
// - key A target follows space; 11 idles
// - instruction between keys aborts the launch
// - busy flag spans the whole operation
// - boot map enable maps boot at F800h
// - only loaded byte positions get programmed
// - erase loaded locations first, then program
// - last loaded page address selects page
// - control register layout; busy read-only
// - boot map enable starts as inverted fuse
//
// The implementer's own choices: the address map and the address-and-strobe port.
module flash_program_memory_ctrl
  import flash_ctrl_pkg::*;
#(
  parameter int PAGE_BYTES = 128,   // bytes per page
  parameter int PAGES      = 128,   // pages in user array
  parameter int BOOT_BYTES = 2048   // boot array size
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  SFR_ADDR,
  input  wire logic [7:0]  SFR_WDATA,
  input  wire logic        SFR_WR,
  input  wire logic        SFR_RD,
  output logic      [7:0]  SFR_RDATA,
  input  wire logic        INSTR_END,
  input  wire logic        EXEC_FROM_BOOT,
  input  wire logic        BOOT_JUMP_FUSE,
  input  wire logic        XDATA_WR,
  input  wire logic [15:0] XDATA_ADDR,
  input  wire logic [7:0]  XDATA_WDATA,
  output logic             LATCH_MAP,
  output logic             LATCH_TAKEN,
  input  wire logic        CODE_RD,
  input  wire logic [15:0] CODE_ADDR,
  output logic      [7:0]  CODE_RDATA,
  output logic             FLASH_BUSY,
  output logic             BOOT_MAPPED,
  input  wire logic        PP_WR,
  input  wire logic        PP_BOOT,
  input  wire logic [15:0] PP_ADDR,
  input  wire logic [7:0]  PP_WDATA
);
  `include "flash_ctrl_params.svh"
  // ==========================================================
  // sizes
  localparam int IDX_W   = $clog2(PAGE_BYTES);  // byte in page
  localparam int PAGE_W  = $clog2(PAGES);       // page number
  localparam int USER_W  = IDX_W + PAGE_W;      // user address
  localparam int BOOT_W  = $clog2(BOOT_BYTES);  // boot address
  localparam int OP_CYCLES = 2 * PAGE_BYTES;    // erase + program
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(PAGE_BYTES - 1);

  // ==========================================================
  // block state, all in one record
  typedef struct packed {
    op_state_e        state;      // programming sequencer
    logic [IDX_W-1:0] idx;        // byte position being walked
    space_e           op_space;   // space of running operation
    logic [7:0]       op_page;    // page of running operation
    logic [7:0]       page_q;     // page of most recent load
    logic             latch_map_select;        // latch map select
    space_e           fmod;       // space select field
    logic             busy;       // flash busy flag
    logic             boot_map;   // boot map enable
    logic             strap_done; // fuse already sampled
    logic [7:0]       sfr_rdata;  // register read answer
    logic [7:0]       code_rdata; // code read answer
    logic             taken;      // a latch load happened
  } st_s;
  st_s q, d;

  // ==========================================================
  // flash arrays; contents persist, so no reset
  logic [7:0] user_mem [PAGES*PAGE_BYTES]; // user array
  logic [7:0] extra_row_mem [PAGE_BYTES];       // extra row
  logic [7:0] boot_mem [BOOT_BYTES];       // boot array
  logic [7:0] hsb_q;                       // security byte

  // ==========================================================
  // decode of the special-register port
  logic       fcr_wr;       // control register write
  logic       acr_wr;       // aux register write
  logic       ld;           // data write taken into latches
  logic       go;           // sequencer launch pulse
  logic       launch;       // launch toward a real space
  logic       allow;        // launch permitted
  space_e     wr_space;     // space field of this write
  logic [7:0] lat_rdata;    // latch byte at walk position
  logic       lat_valid;    // that position was loaded
  logic       mem_we;       // array write during operation
  logic [7:0] mem_wdata;    // byte written to array
  logic       lat_clr;      // drop all loaded flags
  logic       in_user;      // data address in user window
  logic       in_extra_row;      // data address in extra row window

  assign fcr_wr   = SFR_WR && (SFR_ADDR == `FCR_ADDR);
  assign acr_wr   = SFR_WR && (SFR_ADDR == `ACR_ADDR);
  assign wr_space = space_e'(SFR_WDATA[`FCR_SPACE_MSB:`FCR_SPACE_LSB]);
  assign in_user  = (XDATA_ADDR <= `USER_LAST);
  assign in_extra_row  = (XDATA_ADDR >= `EXTRA_ROW_BASE);

  // latch loads take data writes while mapped; eeprom must yield
  assign ld = XDATA_WR && q.latch_map_select && !q.busy && (in_user || in_extra_row);

  // user-array code cannot launch; no launch over a running one
  assign allow  = EXEC_FROM_BOOT && !q.busy;
  assign launch = go && (wr_space != SPACE_RSVD);

  // ==========================================================
  // launch key sequencing
  key_sequencer u_keys (
    .clk       (SYS_CLK),
    .rst       (RST),
    .key_wr    (fcr_wr),
    .key_nib   (SFR_WDATA[`FCR_KEY_MSB:`FCR_KEY_LSB]),
    .instr_end (INSTR_END),
    .allow_go  (allow),
    .go        (go)
  );

  // ==========================================================
  // one page of column latches in front of every space
  page_latch #(
    .DATA_W (8),
    .DEPTH  (PAGE_BYTES)
  ) u_latch (
    .clk    (SYS_CLK),
    .rst    (RST),
    .wr     (ld),
    .widx   (XDATA_ADDR[IDX_W-1:0]),
    .wdata  (XDATA_WDATA),
    .clr    (lat_clr),
    .ridx   (q.idx),
    .rdata  (lat_rdata),
    .rvalid (lat_valid)
  );

  // array writes only at loaded positions, erase pass first
  assign mem_we    = (q.state != OP_IDLE) && lat_valid;
  assign mem_wdata = (q.state == OP_ERASE) ? `ERASED_BYTE
                                           : lat_rdata;
  // flags dropped as the last byte is programmed
  assign lat_clr   = (q.state == OP_PROG) && (q.idx == IDX_LAST);

  // ==========================================================
  // next state of the whole block
  always_comb begin
    d            = q;
    d.taken      = 1'b0;
    d.sfr_rdata  = `SFR_IDLE_READ;   // answer stands one cycle
    d.code_rdata = `ERASED_BYTE;
    // fuse caught on the first edge after reset release
    if (!q.strap_done) begin
      d.strap_done = 1'b1;
      d.boot_map   = ~BOOT_JUMP_FUSE;
    end
    // control register: busy bit is never taken from software
    if (fcr_wr) begin
      d.latch_map_select  = SFR_WDATA[`FCR_LMAP_BIT];
      d.fmod = wr_space;
    end
    // aux register: only boot map enable lives here
    if (acr_wr) begin
      d.boot_map = SFR_WDATA[`ACR_BOOT_BIT];
    end
    // latch load remembers the page, last one wins
    if (ld) begin
      d.page_q = XDATA_ADDR[14:7];
      d.taken  = 1'b1;
    end
    // register reads, unmapped addresses read zero
    if (SFR_RD) begin
      if (SFR_ADDR == `FCR_ADDR) begin
        d.sfr_rdata = {4'h0, q.latch_map_select, q.fmod, q.busy};
      end else if (SFR_ADDR == `ACR_ADDR) begin
        d.sfr_rdata = {2'b00, q.boot_map, 5'b00000};
      end
    end
    // code reads follow boot map, then space select
    if (CODE_RD) begin
      if (q.boot_map && (CODE_ADDR >= `BOOT_BASE)) begin
        d.code_rdata = boot_mem[CODE_ADDR[BOOT_W-1:0]];
      end else begin
        case (q.fmod)
          SPACE_EXTRA_ROW: begin
            if (CODE_ADDR >= `EXTRA_ROW_BASE) begin
              d.code_rdata = extra_row_mem[CODE_ADDR[IDX_W-1:0]];
            end else if (CODE_ADDR <= `USER_LAST) begin
              d.code_rdata = user_mem[CODE_ADDR[USER_W-1:0]];
            end
          end
          SPACE_HSB: begin
            d.code_rdata = hsb_q;
          end
          default: begin
            // user and reserved both show the user array
            if (CODE_ADDR <= `USER_LAST) begin
              d.code_rdata = user_mem[CODE_ADDR[USER_W-1:0]];
            end
          end
        endcase
      end
    end
    // programming sequencer: erase walk then program walk
    case (q.state)
      OP_IDLE: begin
        if (launch) begin
          d.state    = OP_ERASE;
          d.idx      = '0;
          d.busy     = 1'b1;
          d.op_space = wr_space;
          d.op_page  = q.page_q;
        end
      end
      OP_ERASE: begin
        d.idx = IDX_W'(q.idx + 1'b1);
        if (q.idx == IDX_LAST) begin
          d.state = OP_PROG;
        end
      end
      OP_PROG: begin
        d.idx = IDX_W'(q.idx + 1'b1);
        if (q.idx == IDX_LAST) begin
          d.state = OP_IDLE;
          d.busy  = 1'b0;
        end
      end
      default: begin
        d.state = OP_IDLE;
        d.busy  = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // array writes; the boot array takes only the parallel port
  always_ff @(posedge SYS_CLK) begin
    if (mem_we) begin
      case (q.op_space)
        SPACE_USER: begin
          user_mem[{q.op_page[PAGE_W-1:0], q.idx}] <= mem_wdata;
        end
        SPACE_EXTRA_ROW: begin
          extra_row_mem[q.idx] <= mem_wdata;
        end
        SPACE_HSB: begin
          // software reaches the upper nibble only
          if (q.idx == IDX_W'(`HSB_ADDR)) begin
            hsb_q[`HSB_SW_MSB:`HSB_SW_LSB] <=
              mem_wdata[`HSB_SW_MSB:`HSB_SW_LSB];
          end
        end
        default: begin
          // reserved space never reaches here
        end
      endcase
    end
    // parallel programming: boot array and lower security nibble
    if (PP_WR) begin
      if (PP_BOOT) begin
        boot_mem[PP_ADDR[BOOT_W-1:0]] <= PP_WDATA;
      end else begin
        hsb_q[`HSB_HW_MSB:0] <= PP_WDATA[`HSB_HW_MSB:0];
      end
    end
  end

  // ==========================================================
  // outputs, all from the state register
  assign SFR_RDATA   = q.sfr_rdata;
  assign CODE_RDATA  = q.code_rdata;
  assign LATCH_MAP   = q.latch_map_select;
  assign LATCH_TAKEN = q.taken;
  assign FLASH_BUSY  = q.busy;
  assign BOOT_MAPPED = q.boot_map;

  // ==========================================================
  // checks
  sequence s_launch;
    launch;
  endsequence
  sequence s_run_done;
    FLASH_BUSY [*8] ##(OP_CYCLES - 8) FLASH_BUSY ##1 !FLASH_BUSY;
  endsequence

  a_busy_span: assert property (@(posedge SYS_CLK) disable iff (RST)
    s_launch |=> s_run_done)
    else $error("busy did not span erase and program exactly");

  a_user_nolaunch: assert property (@(posedge SYS_CLK) disable iff (RST)
    fcr_wr && !EXEC_FROM_BOOT && !q.busy |=> !FLASH_BUSY)
    else $error("user-array code started programming");

  a_rsvd_idle: assert property (@(posedge SYS_CLK) disable iff (RST)
    fcr_wr && wr_space == SPACE_RSVD && !q.busy |=> !FLASH_BUSY)
    else $error("reserved space started programming");

  a_busy_ro: assert property (@(posedge SYS_CLK) disable iff (RST)
    fcr_wr && !launch && !lat_clr |=> FLASH_BUSY == $past(q.busy))
    else $error("software changed the busy flag");

  a_flag_read: assert property (@(posedge SYS_CLK) disable iff (RST)
    SFR_RD && SFR_ADDR == `FCR_ADDR |=>
      SFR_RDATA == {4'h0, $past(q.latch_map_select), $past(q.fmod), $past(q.busy)})
    else $error("control register read mismatch");

  a_page_last: assert property (@(posedge SYS_CLK) disable iff (RST)
    launch |=> q.op_page == $past(q.page_q))
    else $error("programmed page is not the last loaded one");

  a_erase_first: assert property (@(posedge SYS_CLK) disable iff (RST)
    mem_we && q.state == OP_ERASE |-> mem_wdata == `ERASED_BYTE)
    else $error("erase pass wrote data");

  a_only_loaded: assert property (@(posedge SYS_CLK) disable iff (RST)
    mem_we |-> lat_valid && q.busy)
    else $error("unloaded position written");

  a_latch_route: assert property (@(posedge SYS_CLK) disable iff (RST)
    XDATA_WR && q.latch_map_select && !q.busy && in_user |=> LATCH_TAKEN)
    else $error("mapped data write missed the latches");

  a_fuse_strap: assert property (@(posedge SYS_CLK) disable iff (RST)
    !q.strap_done && !acr_wr |=> BOOT_MAPPED == !$past(BOOT_JUMP_FUSE))
    else $error("boot map not loaded from inverted fuse");
endmodule // flash_program_memory_ctrl

// [dv/cpu_model.sv]
`include "flash_ctrl_params.svh"
// ============================================================
// core side: register, data-move and code-read cycles
module cpu_model (
  input  wire logic        clk,
  input  wire logic [7:0]  sfr_rdata,
  input  wire logic [7:0]  code_rdata,
  input  wire logic        latch_taken,
  output logic      [7:0]  sfr_addr,
  output logic      [7:0]  sfr_wdata,
  output logic             sfr_wr,
  output logic             sfr_rd,
  output logic             instr_end,
  output logic             exec_boot,
  output logic             xdata_wr,
  output logic      [15:0] xdata_addr,
  output logic      [7:0]  xdata_wdata,
  output logic             code_rd,
  output logic      [15:0] code_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet bus at time zero; interrupts never modelled, kept off
  initial begin
    {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, instr_end, exec_boot} = '0;
    {xdata_wr, xdata_addr, xdata_wdata, code_rd, code_addr} = '0;
  end
  // launching code runs from the boot array
  task automatic set_boot(input logic b);
    @(posedge clk);
    exec_boot <= b;
  endtask
  // released lines show the inverse, never the stale value
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk);
    sfr_wr    <= 1'b0;
    sfr_addr  <= ~a;
    sfr_wdata <= ~d;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clk);
    sfr_rd   <= 1'b0;
    sfr_addr <= ~a;
    #1 d = sfr_rdata;
  endtask
  // data-move write into the latch window
  task automatic latch_load(input logic [15:0] a, input logic [7:0] d,
                            output logic t);
    @(posedge clk);
    xdata_addr  <= a;
    xdata_wdata <= d;
    xdata_wr    <= 1'b1;
    @(posedge clk);
    xdata_wr    <= 1'b0;
    xdata_addr  <= ~a;
    xdata_wdata <= ~d;
    #1 t = latch_taken;
  endtask
  task automatic code_read(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    code_addr <= a;
    code_rd   <= 1'b1;
    @(posedge clk);
    code_rd   <= 1'b0;
    code_addr <= ~a;
    #1 d = code_rdata;
  endtask
  // key pair; ends > 1 slips extra instructions in between
  task automatic key_pair(input logic [7:0] k1, input logic [7:0] k2,
                          input int ends);
    @(posedge clk);
    sfr_addr  <= `FCR_ADDR;
    sfr_wdata <= k1;
    sfr_wr    <= 1'b1;
    @(posedge clk);
    sfr_wr    <= 1'b0;
    instr_end <= 1'b1;
    repeat (ends - 1) @(posedge clk);
    @(posedge clk);
    instr_end <= 1'b0;
    sfr_wdata <= k2;
    sfr_wr    <= 1'b1;
    @(posedge clk);
    sfr_wr    <= 1'b0;
    sfr_wdata <= ~k2;
  endtask
endmodule // cpu_model

// [dv/flash_program_memory_ctrl_tb.sv]
`include "flash_ctrl_params.svh"
module flash_program_memory_ctrl_tb;
  import flash_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic        sys_clk, rst, fuse, pp_wr, pp_boot;
  logic [15:0] pp_addr, xa, ca;
  logic [7:0]  pp_wdata, sa, sw, srd, xw, crd, d;
  logic        swr, srdq, iend, eboot, xwr, lmap, ltk, crdq, busy, bmap;
  logic        t;
  int          error_cnt, compares, cyc;
  // 125 MHz
  always #4 sys_clk = ~sys_clk;
  flash_program_memory_ctrl uut (
    .SYS_CLK(sys_clk), .RST(rst), .SFR_ADDR(sa), .SFR_WDATA(sw),
    .SFR_WR(swr), .SFR_RD(srdq), .SFR_RDATA(srd), .INSTR_END(iend),
    .EXEC_FROM_BOOT(eboot), .BOOT_JUMP_FUSE(fuse), .XDATA_WR(xwr),
    .XDATA_ADDR(xa), .XDATA_WDATA(xw), .LATCH_MAP(lmap),
    .LATCH_TAKEN(ltk), .CODE_RD(crdq), .CODE_ADDR(ca),
    .CODE_RDATA(crd), .FLASH_BUSY(busy), .BOOT_MAPPED(bmap),
    .PP_WR(pp_wr), .PP_BOOT(pp_boot), .PP_ADDR(pp_addr),
    .PP_WDATA(pp_wdata));
  cpu_model cpu (
    .clk(sys_clk), .sfr_rdata(srd), .code_rdata(crd), .latch_taken(ltk),
    .sfr_addr(sa), .sfr_wdata(sw), .sfr_wr(swr), .sfr_rd(srdq),
    .instr_end(iend), .exec_boot(eboot), .xdata_wr(xwr), .xdata_addr(xa),
    .xdata_wdata(xw), .code_rd(crdq), .code_addr(ca));
  // ==========================================================
  // compare and report
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    compares++;
    if (got != exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard: whole run is under two thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      stop_test();
    end
  end
  // parallel-programming write, the only path into the boot array
  task automatic pp_write(input logic b, input logic [15:0] a,
                          input logic [7:0] v);
    @(posedge sys_clk);
    pp_boot  <= b;
    pp_addr  <= a;
    pp_wdata <= v;
    pp_wr    <= 1'b1;
    @(posedge sys_clk);
    pp_wr    <= 1'b0;
  endtask
  // key pair then busy level and its length
  task automatic launch(input logic [3:0] lo, input int ends,
                        input logic exp);
    int n;
    n = 0;
    cpu.key_pair({4'h5, lo}, {4'hA, lo}, ends);
    #1;
    chk_byte({7'h0, busy}, {7'h0, exp});
    if (exp) begin
      while (busy === 1'b1 && n < 400) begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      chk_cnt(n, 2 * 128);
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {sys_clk, fuse, pp_wr, pp_boot, pp_addr, pp_wdata} = '0;
    {error_cnt, compares, cyc} = '0;
    rst = 1'b1;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1 chk_byte({7'h0, bmap}, 8'h01);
    cpu.set_boot(1'b1);
    cpu.reg_read(`ACR_ADDR, d);
    chk_byte(d, 8'h20);
    cpu.reg_read(`FCR_ADDR, d);
    chk_byte(d, `FCR_RESET);
    // busy and key bits must not stick
    cpu.reg_write(`FCR_ADDR, 8'hFF);
    cpu.reg_read(`FCR_ADDR, d);
    chk_byte(d, 8'h0E);
    pp_write(1'b1, 16'h0010, 8'hC3);
    cpu.code_read(16'hF810, d);
    chk_byte(d, 8'hC3);
    // user page: byte 6 of page 2 first
    cpu.reg_write(`FCR_ADDR, 8'h08);
    #1 chk_byte({7'h0, lmap}, 8'h01);
    cpu.latch_load(16'h0106, 8'hAA, t);
    chk_byte({7'h0, t}, 8'h01);
    launch(4'h0, 1, 1'b1);
    // earlier page 3 addresses, last load on page 2
    cpu.reg_write(`FCR_ADDR, 8'h08);
    cpu.latch_load(16'h0185, 8'h5A, t);
    cpu.latch_load(16'h0187, 8'h3C, t);
    cpu.latch_load(16'h4000, 8'h99, t);
    chk_byte({7'h0, t}, 8'h00);
    cpu.latch_load(16'h0109, 8'h11, t);
    launch(4'h0, 1, 1'b1);
    // byte 6 was not reloaded, so it must keep its value
    cpu.code_read(16'h0106, d);
    chk_byte(d, 8'hAA);
    // reloaded byte is erased, then written again
    cpu.reg_write(`FCR_ADDR, 8'h08);
    cpu.latch_load(16'h0106, 8'h55, t);
    launch(4'h0, 1, 1'b1);
    // launch keeping the latch map; loads refused while busy
    cpu.key_pair(8'h58, 8'hA8, 1);
    cpu.latch_load(16'h0106, 8'h77, t);
    chk_byte({7'h0, t}, 8'h00);
    wait (busy === 1'b0);
    cpu.reg_write(`FCR_ADDR, 8'h00);
    cpu.code_read(16'h0105, d);
    chk_byte(d, 8'h5A);
    cpu.code_read(16'h0107, d);
    chk_byte(d, 8'h3C);
    cpu.code_read(16'h0109, d);
    chk_byte(d, 8'h11);
    cpu.code_read(16'h0106, d);
    chk_byte(d, 8'h55);
    // refused launches: user code, gap, disarm, reserved space
    cpu.reg_write(`FCR_ADDR, 8'h08);
    cpu.latch_load(16'h0106, 8'h66, t);
    cpu.set_boot(1'b0);
    launch(4'h0, 1, 1'b0);
    cpu.set_boot(1'b1);
    launch(4'h0, 2, 1'b0);
    launch(4'h6, 1, 1'b0);
    cpu.reg_write(`FCR_ADDR, 8'h50);
    cpu.reg_write(`FCR_ADDR, 8'h40);
    cpu.reg_write(`FCR_ADDR, 8'hA0);
    #1 chk_byte({7'h0, busy}, 8'h00);
    cpu.code_read(16'h0106, d);
    chk_byte(d, 8'h55);
    // extra row
    cpu.reg_write(`FCR_ADDR, 8'h0A);
    cpu.latch_load(16'hFF83, 8'h77, t);
    chk_byte({7'h0, t}, 8'h01);
    launch(4'h2, 1, 1'b1);
    cpu.reg_write(`FCR_ADDR, 8'h00);
    cpu.code_read(16'hF810, d);
    chk_byte(d, 8'hC3);
    cpu.reg_write(`ACR_ADDR, 8'h00);
    cpu.reg_read(`ACR_ADDR, d);
    chk_byte(d, 8'h00);
    cpu.code_read(16'hF810, d);
    chk_byte(d, 8'hFF);
    cpu.reg_write(`FCR_ADDR, 8'h02);
    cpu.code_read(16'hFF83, d);
    chk_byte(d, 8'h77);
    // security byte: software nibble high, parallel nibble low
    pp_write(1'b0, 16'h0000, 8'h05);
    cpu.reg_write(`FCR_ADDR, 8'h0C);
    cpu.latch_load(16'h0000, 8'hA3, t);
    launch(4'h4, 1, 1'b1);
    cpu.reg_write(`FCR_ADDR, 8'h04);
    cpu.code_read(16'h1234, d);
    chk_byte(d, 8'hA5);
    cpu.reg_write(`FCR_ADDR, 8'h00);
    stop_test();
  end
endmodule // flash_program_memory_ctrl_tb
